//--- hdl/ssn_pkg.sv
// constants, types and helpers for the slot and sample timebase
package ssn_pkg;
    localparam int unsigned CLK_HZ    = 10_000_000;
    localparam int unsigned SAMPLE_HZ = 48_000;
    localparam int unsigned ACC_W     = 24;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(SAMPLE_HZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);

    localparam int unsigned SAMPLE_W = 11;
    localparam int unsigned SLOT_W   = 12;
    localparam int unsigned SLOT_LSB = 16;
    localparam logic [SAMPLE_W-1:0] SAMPLE_LAST = 11'h4FF;
    localparam logic [SLOT_W-1:0]   SLOT_LAST   = 12'h8C9;
    localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 11'h000;
    localparam logic [SLOT_W-1:0]   SLOT_ZERO   = 12'h000;
    localparam logic [15:0]         ADJ_ZERO    = 16'h0000;

    localparam logic [12:0] ODD_LO     = 13'h0140;
    localparam logic [12:0] ODD_HI     = 13'h03C0;
    localparam logic [12:0] ODD_CENTRE = 13'h0280;

    localparam logic [7:0] ADDR_VALUE   = 8'h11;
    localparam logic [7:0] ADDR_DOZE    = 8'h12;
    localparam logic [7:0] ADDR_RESUME  = 8'h13;
    localparam logic [7:0] ADDR_COARSE  = 8'h15;
    localparam logic [7:0] ADDR_FINE    = 8'h16;
    localparam logic [7:0] ADDR_ADJPT   = 8'h17;
    localparam logic [7:0] ADDR_LIMIT   = 8'h18;
    localparam logic [7:0] ADDR_CAPTURE = 8'h19;

    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_ACQUIRE,
        MODE_TRACK,
        MODE_RESERVED
    } ssn_mode_e;

    typedef struct packed {
        logic [SLOT_W-1:0]   slot;
        logic [SAMPLE_W-1:0] sample;
    } ssn_count_s;

    // register layout shared by live value and captured copy
    function automatic logic [31:0] ssn_pack(input ssn_count_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SLOT_LSB +: SLOT_W] = c.slot;
        w[SAMPLE_W-1:0]       = c.sample;
        return w;
    endfunction
endpackage

//--- hdl/ssn_timebase.sv
// slot and sample timebase with capture, sleep points and corrections
module ssn_timebase
    import ssn_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata_q,
    input  wire logic [1:0]  adjust_mode,
    input  wire logic        doze_enable,
    input  wire logic [1:0]  slot_inactive,
    input  wire logic        second_mark_in,
    output logic      [1:0]  rx_doze_q,
    output logic             correction_applied_irq_q
);
    ssn_count_s            cnt_q;
    ssn_count_s            cnt_d;
    ssn_count_s            capture_q;
    logic [ACC_W-1:0]      acc_q;
    logic [SAMPLE_W-1:0]   doze_pt_q;
    logic [SAMPLE_W-1:0]   resume_pt_q;
    logic [SAMPLE_W-1:0]   adj_pt_q;
    logic [SAMPLE_W-1:0]   limit_q;
    logic [15:0]           coarse_q;
    logic [15:0]           fine_q;
    logic                  armed_q;
    logic                  auto_pend_q;
    logic [12:0]           auto_nudge_q;
    logic                  mark_prev_q;

    ssn_mode_e             mode;
    logic [ACC_W:0]        acc_sum;
    logic                  tick;
    logic                  mark_rise;
    logic                  at_trigger;
    logic                  manual_apply;
    logic                  auto_apply;
    logic                  apply;
    logic                  sample_wrap;
    logic [SAMPLE_W-1:0]   sample_step;
    logic signed [17:0]    slot_sum;
    logic signed [17:0]    slot_mod;
    logic [SLOT_W-1:0]     slot_adj;
    logic [SLOT_W-1:0]     slot_step;
    logic signed [15:0]    sample_nudge;
    logic signed [12:0]    raw_nudge;
    logic signed [12:0]    lim_pos;
    logic signed [12:0]    clamped;
    logic [12:0]           mark_sample;
    logic                  wr_coarse;
    logic                  wr_fine;
    logic                  slot_nudged;
    logic [31:0]           rd_mux;

    assign mode = ssn_mode_e'(adjust_mode);

    // fractional divider: exact 48 kHz on average from the 10 MHz clock
    assign acc_sum = {1'b0, acc_q} + {1'b0, ACC_STEP};
    assign tick    = acc_sum >= {1'b0, ACC_WRAP};

    assign mark_rise = second_mark_in & ~mark_prev_q;
    assign wr_coarse = reg_wr && reg_addr == ADDR_COARSE;
    assign wr_fine   = reg_wr && reg_addr == ADDR_FINE;

    assign at_trigger   = tick && cnt_q.sample == adj_pt_q;
    assign manual_apply = at_trigger && armed_q && mode == MODE_MANUAL;
    assign auto_apply   = at_trigger && auto_pend_q &&
                          (mode == MODE_ACQUIRE || mode == MODE_TRACK);
    assign apply        = manual_apply || auto_apply;
    assign slot_nudged  = auto_apply && mode == MODE_TRACK && coarse_q != ADJ_ZERO;

    // fine adjust is ignored outside manual mode
    assign sample_nudge = manual_apply ? $signed(fine_q)
                                       : 16'($signed(auto_nudge_q));

    // no wrap under correction: a bad sum can leave the legal range
    assign sample_wrap = cnt_q.sample == SAMPLE_LAST;
    assign sample_step = sample_wrap ? SAMPLE_ZERO : cnt_q.sample + 11'h001;
    assign slot_step   = cnt_q.slot == SLOT_LAST ? SLOT_ZERO
                                                 : cnt_q.slot + 12'h001;

    assign slot_sum = $signed({6'h00, cnt_q.slot}) + 18'($signed(coarse_q));
    assign slot_mod = slot_sum % $signed({6'h00, SLOT_LAST + 12'h001});
    assign slot_adj = slot_mod < 0
                    ? SLOT_W'(slot_mod + $signed({6'h00, SLOT_LAST + 12'h001}))
                    : SLOT_W'(slot_mod);

    always_comb begin
        cnt_d = cnt_q;
        if (apply) begin
            // correction takes the place of the normal step
            cnt_d.sample = SAMPLE_W'($signed({5'h00, cnt_q.sample}) + sample_nudge);
            if (manual_apply || slot_nudged) begin
                cnt_d.slot = slot_adj;
            end
        end else if (tick) begin
            cnt_d.sample = sample_step;
            if (sample_wrap) begin
                cnt_d.slot = slot_step;
            end
        end
    end

    // track mode: odd seconds sit mid slot, even seconds on a boundary
    assign mark_sample = {2'b00, cnt_q.sample};
    assign raw_nudge = (mark_sample >= ODD_LO && mark_sample < ODD_HI)
                     ? $signed(ODD_CENTRE - mark_sample)
                     : -$signed(mark_sample);
    assign lim_pos = $signed({2'b00, limit_q});
    assign clamped = raw_nudge > lim_pos  ? lim_pos
                   : raw_nudge < -lim_pos ? -lim_pos
                   : raw_nudge;

    always_comb begin
        unique case (reg_addr)
            ADDR_VALUE:   rd_mux = ssn_pack(cnt_q);
            ADDR_CAPTURE: rd_mux = ssn_pack(capture_q);
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q       <= '0;
            cnt_q       <= '0;
            mark_prev_q <= 1'b0;
        end else begin
            acc_q       <= tick ? ACC_W'(acc_sum - {1'b0, ACC_WRAP}) : acc_sum[ACC_W-1:0];
            cnt_q       <= cnt_d;
            mark_prev_q <= second_mark_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            capture_q <= '0;
        end else if (mark_rise) begin
            capture_q <= cnt_q;
        end
    end

    // threshold registers keep only the sample field
    always_ff @(posedge clk) begin
        if (rst) begin
            doze_pt_q   <= SAMPLE_ZERO;
            resume_pt_q <= SAMPLE_ZERO;
            adj_pt_q    <= SAMPLE_ZERO;
            limit_q     <= SAMPLE_ZERO;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_DOZE)   doze_pt_q   <= reg_wdata[SAMPLE_W-1:0];
            if (reg_addr == ADDR_RESUME) resume_pt_q <= reg_wdata[SAMPLE_W-1:0];
            if (reg_addr == ADDR_ADJPT)  adj_pt_q    <= reg_wdata[SAMPLE_W-1:0];
            if (reg_addr == ADDR_LIMIT)  limit_q     <= reg_wdata[SAMPLE_W-1:0];
        end
    end

    // a host write in the apply cycle wins so the new value is not lost
    always_ff @(posedge clk) begin
        if (rst) begin
            coarse_q <= ADJ_ZERO;
            fine_q   <= ADJ_ZERO;
            armed_q  <= 1'b0;
        end else begin
            if (wr_coarse) begin
                coarse_q <= reg_wdata;
            end else if (manual_apply || slot_nudged) begin
                coarse_q <= ADJ_ZERO;
            end
            if (wr_fine) begin
                fine_q  <= reg_wdata;
                armed_q <= 1'b1;
            end else if (manual_apply) begin
                fine_q  <= ADJ_ZERO;
                armed_q <= 1'b0;
            end
        end
    end

    // acquire: a correction from each mark taken while none is pending; track: every second
    always_ff @(posedge clk) begin
        if (rst) begin
            auto_pend_q  <= 1'b0;
            auto_nudge_q <= '0;
        end else if (mark_rise && mode == MODE_TRACK) begin
            auto_pend_q  <= 1'b1;
            auto_nudge_q <= clamped;
        end else if (mark_rise && mode == MODE_ACQUIRE && !auto_pend_q) begin
            auto_pend_q  <= 1'b1;
            auto_nudge_q <= -mark_sample;
        end else if (auto_apply || mode == MODE_MANUAL) begin
            auto_pend_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            correction_applied_irq_q <= 1'b0;
        end else begin
            correction_applied_irq_q <= manual_apply || slot_nudged ||
                                        (auto_apply && mode == MODE_ACQUIRE);
        end
    end

    // per receive channel sleep window inside an inactive slot
    for (genvar ch = 0; ch < 2; ch++) begin : g_doze
        always_ff @(posedge clk) begin
            if (rst) begin
                rx_doze_q[ch] <= 1'b0;
            end else if (cnt_q.sample == resume_pt_q) begin
                rx_doze_q[ch] <= 1'b0;
            end else if (doze_enable && slot_inactive[ch] && cnt_q.sample == doze_pt_q) begin
                rx_doze_q[ch] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sample_range_kept: assert property (
        tick && !apply && cnt_q.sample == SAMPLE_LAST |=> cnt_q.sample == SAMPLE_ZERO)
        else $error("sample counter did not roll over at last value");

    a_slot_step_on_wrap: assert property (
        tick && !apply && sample_wrap |=> cnt_q.slot == $past(slot_step))
        else $error("slot counter did not advance on sample rollover");

    a_slot_hold_mid: assert property (
        !apply && !sample_wrap |=> $stable(cnt_q.slot))
        else $error("slot counter moved without rollover");

    a_value_read_layout: assert property (
        reg_rd && reg_addr == ADDR_VALUE |=>
            reg_rdata_q[31:28] == 4'h0 && reg_rdata_q[15:11] == 5'h00 &&
            reg_rdata_q[SAMPLE_W-1:0] == $past(cnt_q.sample))
        else $error("live value read has wrong layout");

    a_capture_on_mark: assert property (
        mark_rise |=> capture_q == $past(cnt_q))
        else $error("capture did not copy live value on mark edge");

    a_doze_at_point: assert property (
        doze_enable && slot_inactive[0] && cnt_q.sample == doze_pt_q &&
        cnt_q.sample != resume_pt_q |=> rx_doze_q[0])
        else $error("channel a did not doze at doze point");

    a_resume_at_point: assert property (
        cnt_q.sample == resume_pt_q |=> rx_doze_q == 2'b00)
        else $error("receivers did not resume at resume point");

    a_manual_clears: assert property (
        manual_apply && !reg_wr |=> fine_q == ADJ_ZERO && coarse_q == ADJ_ZERO
            ##0 correction_applied_irq_q)
        else $error("manual apply did not clear adjusts and signal done");

    a_fine_ignored_auto: assert property (
        tick && mode != MODE_MANUAL && !apply |=> cnt_q.sample == $past(sample_step))
        else $error("fine adjust applied outside manual mode");

    a_track_clamped: assert property (
        mark_rise && mode == MODE_TRACK |=>
            $signed(auto_nudge_q) <= $signed({2'b00, limit_q}) &&
            $signed(auto_nudge_q) >= -$signed({2'b00, limit_q}))
        else $error("track correction exceeds limit");

    a_slot_wraps_legal: assert property (
        manual_apply |=> cnt_q.slot <= SLOT_LAST)
        else $error("slot counter left legal range after correction");

    a_slot_wrap_back: assert property (
        manual_apply && coarse_q == 16'hFFFF && cnt_q.slot == SLOT_ZERO |=>
            cnt_q.slot == SLOT_LAST)
        else $error("slot counter did not wrap backwards past zero");

    a_trigger_applies: assert property (
        at_trigger && armed_q && mode == MODE_MANUAL |=>
            cnt_q.sample == SAMPLE_W'($past(cnt_q.sample) + $past(fine_q)))
        else $error("armed correction not applied at adjust point");

    a_step_off_trigger: assert property (
        tick && !apply && cnt_q.sample != SAMPLE_LAST |=> cnt_q.sample == $past(cnt_q.sample) + 11'h001)
        else $error("sample counter did not step by one");

    a_fine_arms: assert property (
        wr_fine |=> armed_q && fine_q == $past(reg_wdata))
        else $error("fine adjust write did not arm corrections");

    a_coarse_taken: assert property (
        wr_coarse |=> coarse_q == $past(reg_wdata))
        else $error("coarse adjust write was not taken");

    a_done_single: assert property (
        correction_applied_irq_q |=> !correction_applied_irq_q)
        else $error("done pulse lasted more than one cycle");

    a_read_stands: assert property (
        !reg_rd |=> $stable(reg_rdata_q))
        else $error("read data changed without a read strobe");

    a_doze_pt_masked: assert property (
        reg_wr && reg_addr == ADDR_DOZE |=> doze_pt_q == $past(reg_wdata[SAMPLE_W-1:0]))
        else $error("doze point did not keep only the sample field");

    a_capture_holds: assert property (
        !mark_rise |=> $stable(capture_q))
        else $error("capture changed without a mark edge");

    // reset itself is checked, so the default disable is switched off here
    a_reset_clears: assert property (disable iff (1'b0)
        rst |=> cnt_q.slot == SLOT_ZERO && cnt_q.sample == SAMPLE_ZERO && !armed_q &&
            coarse_q == ADJ_ZERO && fine_q == ADJ_ZERO && rx_doze_q == 2'b00 &&
            !correction_applied_irq_q && reg_rdata_q == 32'h0000_0000)
        else $error("reset left timebase state set");
endmodule

//--- tb/ssn_host.sv
// host model: drives the register strobes of the timebase
module ssn_host
    import ssn_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [31:0] reg_rdata_q,
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic      [15:0] reg_wdata,
    output logic             reg_rd
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end

    // the second edge keeps two strobe assignments out of one time step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata_q;
    endtask

    // slot adjust goes first since the fine write arms both
    task automatic nudge(input logic [15:0] c, input logic [15:0] f, input logic [10:0] ap);
        int s;
        s = int'(ap) + int'($signed(f));
        if (s >= 0 && s <= 1279) begin
            if (c != 16'h0000) wr(ADDR_COARSE, c);
            wr(ADDR_FINE, f);
        end
    endtask
endmodule

//--- tb/ssn_timebase_bench.sv
// self-checking bench for the slot and sample timebase
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); end end
module ssn_timebase_bench
    import ssn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, reg_wr, reg_rd, doze_enable, second_mark_in, irq;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [31:0] rdata, v, w;
    logic [1:0]  adjust_mode, slot_inactive, rx_doze;
    logic [10:0] ap, s, d;
    int          fails = 0, n_tests = 0, n_irq = 0, k, lim;

    ssn_timebase dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(rdata), .adjust_mode(adjust_mode), .doze_enable(doze_enable),
        .slot_inactive(slot_inactive), .second_mark_in(second_mark_in), .rx_doze_q(rx_doze),
        .correction_applied_irq_q(irq));
    ssn_host h (.clk(clk), .reg_rdata_q(rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;

    function automatic logic [31:0] pk(input logic [11:0] sl, input logic [10:0] sa);
        return {4'h0, sl, 5'h00, sa};
    endfunction

    function automatic logic [10:0] trk(input logic [10:0] a, input logic [10:0] sm, input int l);
        int n;
        n = (sm >= 11'd320 && sm < 11'd960) ? 640 - int'(sm) : -int'(sm);
        if (n > l) n = l;
        if (n < -l) n = -l;
        return 11'(int'(a) + n);
    endfunction

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic bust();
        fails++;
        stop_test();
    endtask

    // polling every two cycles cannot miss a sample value that lasts about 208
    task automatic wait_trig(input logic [10:0] a);
        int i;
        for (i = 0; i < 4000 && v[10:0] !== a; i++) h.rd(ADDR_VALUE, v);
        if (i == 4000) bust();
        for (i = 0; i < 200 && v[10:0] === a; i++) h.rd(ADDR_VALUE, v);
        if (i == 200) bust();
    endtask

    task automatic wait_doze(input logic lvl);
        int i;
        for (i = 0; i < 3000 && rx_doze[0] !== lvl; i++) @(posedge clk);
        if (i == 3000) bust();
    endtask

    initial begin
        rst = 1'b1;
        adjust_mode = MODE_MANUAL;
        doze_enable = 1'b0;
        slot_inactive = 2'b00;
        second_mark_in = 1'b0;
        void'($urandom(32'h5108));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({rx_doze, irq}, 3'b000)
        h.rd(ADDR_VALUE, v);
        `CHK(v, 32'h0000_0000)
        h.rd(ADDR_CAPTURE, v);
        `CHK(v, 32'h0000_0000)
        h.rd(ADDR_DOZE, v);
        `CHK(v, 32'h0000_0000)
        h.rd(8'h14, v);
        `CHK(v, 32'h0000_0000)
        h.rd(ADDR_VALUE, v);
        repeat (2500) @(posedge clk);
        h.rd(ADDR_VALUE, w);
        d = w[10:0] - v[10:0];
        `CHK((d >= 11'd11) && (d <= 11'd13), 1'b1)
        second_mark_in <= 1'b1;
        h.rd(ADDR_VALUE, v);
        h.rd(ADDR_CAPTURE, w);
        `CHK(w, v)
        second_mark_in <= 1'b0;
        // upper bits set on purpose: they must be dropped
        s = v[10:0] + 11'd2 + 11'($urandom_range(0, 2));
        h.wr(ADDR_DOZE, {5'h1F, s});
        h.wr(ADDR_RESUME, {5'h1F, s + 11'd3});
        doze_enable <= 1'b1;
        slot_inactive <= 2'b01;
        wait_doze(1'b1);
        h.rd(ADDR_VALUE, v);
        `CHK({rx_doze[1], v[10:0]}, {1'b0, s})
        wait_doze(1'b0);
        h.rd(ADDR_VALUE, v);
        `CHK(v[10:0], s + 11'd3)
        doze_enable <= 1'b0;
        ap = v[10:0] + 11'd3;
        h.wr(ADDR_ADJPT, {5'h00, ap});
        k = n_irq;
        h.nudge(16'hFFFF, 16'(1275 - int'(ap)), ap);
        wait_trig(ap);
        `CHK(v, pk(12'd2249, 11'd1275))
        `CHK(n_irq, k + 1)
        repeat (1254) @(posedge clk);
        h.rd(ADDR_VALUE, v);
        `CHK({v[27:16], v[10:0] <= 11'd2}, {12'h000, 1'b1})
        ap = v[10:0] + 11'd3 + 11'($urandom_range(0, 19));
        s = 11'($urandom_range(0, 600));
        if (s == ap) s = s + 11'd2;
        h.wr(ADDR_ADJPT, {5'h00, ap});
        k = n_irq;
        h.nudge(16'h0000, 16'(int'(s) - int'(ap)), ap);
        wait_trig(ap);
        `CHK(v, pk(12'h000, s))
        `CHK(n_irq, k + 1)
        k = n_irq;
        adjust_mode <= MODE_ACQUIRE;
        ap = v[10:0] + 11'd3;
        h.wr(ADDR_ADJPT, {5'h00, ap});
        h.wr(ADDR_FINE, 16'h000A);
        wait_trig(ap);
        `CHK(v[10:0], ap + 11'd1)
        adjust_mode <= MODE_TRACK;
        lim = int'($urandom_range(2, 6));
        h.wr(ADDR_LIMIT, {5'h1F, 11'(lim)});
        ap = v[10:0] + 11'd4;
        h.wr(ADDR_ADJPT, {5'h00, ap});
        second_mark_in <= 1'b1;
        h.rd(ADDR_CAPTURE, w);
        second_mark_in <= 1'b0;
        h.rd(ADDR_CAPTURE, w);
        wait_trig(ap);
        `CHK(v[10:0], trk(ap, w[10:0], lim))
        `CHK(n_irq, k)
        // mid-run reset: an armed fine adjust must not survive it
        adjust_mode <= MODE_MANUAL;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        h.rd(ADDR_VALUE, v);
        `CHK({v, rx_doze, irq}, 35'h0)
        repeat (300) @(posedge clk);
        h.rd(ADDR_VALUE, v);
        `CHK(v, pk(12'h000, 11'd1))
        stop_test();
    end
endmodule
